/* File: rtl/dcl_arbiter.v */
// fixed-priority pick among four channel requests
`timescale 1ns/1ps
module dcl_arbiter (
	input wire [3:0] req,
	output reg any,
	output reg [1:0] pick
);
	// ----------------------------------------
	// channel 0 highest
	// ----------------------------------------
	always @* begin
		any = |req;
		pick = 2'h3;
		if (req[2])
			pick = 2'h2;
		if (req[1])
			pick = 2'h1;
		if (req[0])
			pick = 2'h0;
	end
endmodule // dcl_arbiter

/* File: rtl/dcl_consts.vh */
// constants for the four-channel dma link and transfer-check block
`ifndef DCL_CONSTS_VH
`define DCL_CONSTS_VH
// register map: channel n sits at base 0x10 * n
`define DCL_OFF_SRC 4'h0
`define DCL_OFF_DST 4'h4
`define DCL_OFF_CNT 4'h8
`define DCL_OFF_CTRL 4'hC
`define DCL_CH_STRIDE_SHIFT 4
// control fields
`define DCL_CTRL_SECOND_LO 0
`define DCL_CTRL_FIRST_LO 2
`define DCL_CTRL_LINK_LO 4
`define DCL_CTRL_RSVD_BIT 6
`define DCL_CTRL_DREQ_BIT 7
`define DCL_CTRL_IRQ_EN_BIT 8
`define DCL_CTRL_DESTINATION_SIZE_LO 17
`define DCL_CTRL_DINC_BIT 19
`define DCL_CTRL_SOURCE_SIZE_LO 20
`define DCL_CTRL_SINC_BIT 22
`define DCL_CTRL_AA_BIT 28
`define DCL_CTRL_CS_BIT 29
`define DCL_CTRL_ERQ_BIT 30
`define DCL_CTRL_START_BIT 16
`define DCL_CTRL_WMASK 32'hF07F_01BF
`define DCL_CTRL_RESET 32'h0000_0000
// status fields in the byte-count word
`define DCL_CNT_W 24
`define DCL_STAT_DONE_BIT 24
`define DCL_STAT_BUSY_BIT 25
`define DCL_STAT_CE_BIT 30
// size codes
`define DCL_SZ_32 2'h0
`define DCL_SZ_8 2'h1
`define DCL_SZ_16 2'h2
// link control codes
`define DCL_LINK_NONE 2'h0
`define DCL_LINK_STEP_LAST 2'h1
`define DCL_LINK_STEP 2'h2
`define DCL_LINK_LAST 2'h3
// bus answers
`define DCL_RESP_OKAY 2'h0
`define DCL_RESP_SLVERR 2'h2
`endif

/* File: rtl/dcl_dma.v */
// four-channel dma core with linking, size checks and an axi4-lite slave
// Behaviour
// (R1) link code zero never triggers another channel
// (R2) code 01: first each step, second last
// (R3) code 10: first after each step only
// (R4) code 11: first once at count zero
// (R5) continuous mode suppresses per-step first links
// (R6) link event requests the linked channel
// (R7) first link equal to self flags error
// (R8) second link equal to self flags error
// (R9) control bit 6 always reads zero
// (R10) request is start bit or enabled peripheral
// (R11) start bit clears on activation
// (R12) sizes checked against addresses before access
// (R13) misalignment: no transfer, error, optional interrupt
// (R14) auto-align narrows the size check
// (R15) read then write, larger size bytes
// (R16) addresses increment after successful transfer only
// (R17) auto-align checks only the unaligned side
// (R18) steal: one transfer; continuous: until zero
// (R19) disable-request clears enable at count zero
// (R20) fixed priority, channel 0 first, run to end
// (R21) link requests held and arbitrated alike
// (R22) self-link error checked before any access
`timescale 1ns/1ps
`include "dcl_consts.vh"
module dcl_dma (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_awaddr,
	input wire s_awvalid,
	output reg s_awready,
	input wire [31:0] s_wdata,
	input wire [3:0] s_wstrb,
	input wire s_wvalid,
	output reg s_wready,
	output reg [1:0] s_bresp,
	output reg s_bvalid,
	input wire s_bready,
	input wire [7:0] s_araddr,
	input wire s_arvalid,
	output reg s_arready,
	output reg [31:0] s_rdata,
	output reg [1:0] s_rresp,
	output reg s_rvalid,
	input wire s_rready,
	input wire [3:0] periph_req,
	output reg [31:0] mem_addr,
	output reg [1:0] mem_size,
	output reg mem_read,
	output reg mem_write,
	output reg [31:0] mem_wdata,
	input wire [31:0] mem_rdata,
	input wire mem_ack,
	output reg [3:0] irq_event
);
	localparam ST_IDLE = 2'h0;
	localparam ST_READ = 2'h1;
	localparam ST_WRITE = 2'h2;
	localparam ST_NEXT = 2'h3;
	reg [31:0] src [0:3];
	reg [31:0] dst [0:3];
	reg [23:0] cnt [0:3];
	reg [31:0] ctrl [0:3];
	reg [3:0] done;
	reg [3:0] cerr;
	reg [3:0] link_req;
	reg [1:0] state;
	reg [1:0] cur;
	reg [31:0] data;
	reg aw_held, w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire [3:0] chan_req;
	wire arb_any;
	wire [1:0] arb_pick;
	genvar g;
	// ----------------------------------------
	// request terms
	// ----------------------------------------
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_req
			// (R10) start or enabled peripheral
			// (R21) held link request joins
			assign chan_req[g] = ctrl[g][`DCL_CTRL_START_BIT] |
				(ctrl[g][`DCL_CTRL_ERQ_BIT] & periph_req[g]) | link_req[g];
		end
	endgenerate
	// (R20) fixed priority arbitration
	dcl_arbiter u_arb (
		.req(chan_req),
		.any(arb_any),
		.pick(arb_pick)
	);
	// ----------------------------------------
	// current channel decode
	// ----------------------------------------
	wire [31:0] cc = ctrl[cur];
	wire [31:0] cs = src[cur];
	wire [31:0] cd = dst[cur];
	wire [23:0] cb = cnt[cur];
	wire [1:0] ssz = cc[`DCL_CTRL_SOURCE_SIZE_LO +: 2];
	wire [1:0] dsz = cc[`DCL_CTRL_DESTINATION_SIZE_LO +: 2];
	wire [1:0] lk = cc[`DCL_CTRL_LINK_LO +: 2];
	wire [1:0] first_link_channel = cc[`DCL_CTRL_FIRST_LO +: 2];
	wire [1:0] second_link_channel = cc[`DCL_CTRL_SECOND_LO +: 2];
	wire steal = cc[`DCL_CTRL_CS_BIT];
	wire aa = cc[`DCL_CTRL_AA_BIT];
	function [2:0] nbytes;
		input [1:0] sz;
		begin
			nbytes = (sz == `DCL_SZ_8) ? 3'h1 : (sz == `DCL_SZ_16) ? 3'h2 : 3'h4;
		end
	endfunction
	function misal;
		input [1:0] sz;
		input [31:0] a;
		begin
			misal = (sz == 2'h3) | ((sz == `DCL_SZ_16) & a[0]) |
				((sz == `DCL_SZ_32) & (a[1:0] != 2'h0));
		end
	endfunction
	wire [2:0] sbytes = nbytes(ssz);
	wire [2:0] dbytes = nbytes(dsz);
	// (R15) larger of the two sizes moves
	wire [2:0] xbytes = (sbytes > dbytes) ? sbytes : dbytes;
	wire [1:0] xsz = (sbytes > dbytes) ? ssz : dsz;
	// (R14) (R17) source aligned when not smaller, destination otherwise
	wire src_aligned = aa & (sbytes >= dbytes);
	wire dst_aligned = aa & (sbytes < dbytes);
	// (R12) size against address check
	wire size_bad = (~src_aligned & misal(ssz, cs)) | (~dst_aligned & misal(dsz, cd));
	// (R7) (R8) self link check
	wire link_bad = (lk != `DCL_LINK_NONE) & ((first_link_channel == cur) |
		((lk == `DCL_LINK_STEP_LAST) & (second_link_channel == cur)));
	wire [23:0] cb_next = cb - {21'h0, xbytes};
	wire last = (cb <= {21'h0, xbytes});
	// ----------------------------------------
	// axi4-lite write decode
	// ----------------------------------------
	wire [1:0] wch = aw_addr[5:4];
	wire [3:0] wreg = aw_addr[3:0];
	wire wr_go = aw_held & w_held & ~s_bvalid;
	wire wr_hit = (aw_addr[7:6] == 2'h0);
	wire [31:0] bmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [31:0] m;
		begin
			merge = (old & ~m) | (nw & m);
		end
	endfunction
	wire [31:0] cnt_merged = merge({8'h00, cnt[wch]}, w_data, bmask);
	// ----------------------------------------
	// bus slave handshakes
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= `DCL_RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			s_awready <= ~aw_held & ~s_awready & s_awvalid;
			s_wready <= ~w_held & ~s_wready & s_wvalid;
			if (s_awvalid & s_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_awaddr;
			end
			if (s_wvalid & s_wready) begin
				w_held <= 1'b1;
				w_data <= s_wdata;
				w_strb <= s_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= wr_hit ? `DCL_RESP_OKAY : `DCL_RESP_SLVERR;
			end else if (s_bready)
				s_bvalid <= 1'b0;
		end
	end
	// ----------------------------------------
	// read channel
	// ----------------------------------------
	wire [1:0] rch = s_araddr[5:4];
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= `DCL_RESP_OKAY;
		end else begin
			s_arready <= ~s_rvalid & ~s_arready & s_arvalid;
			if (s_arvalid & s_arready) begin
				s_rvalid <= 1'b1;
				s_rresp <= (s_araddr[7:6] == 2'h0) ? `DCL_RESP_OKAY : `DCL_RESP_SLVERR;
				case (s_araddr[3:0])
					`DCL_OFF_SRC: s_rdata <= src[rch];
					`DCL_OFF_DST: s_rdata <= dst[rch];
					`DCL_OFF_CNT: s_rdata <= {1'b0, cerr[rch], 4'h0,
						(state != ST_IDLE) && (cur == rch), done[rch], cnt[rch]};
					// (R9) reserved bit reads zero
					`DCL_OFF_CTRL: s_rdata <= ctrl[rch] & `DCL_CTRL_WMASK;
					default: s_rdata <= 32'h0000_0000;
				endcase
				if (s_araddr[7:6] != 2'h0)
					s_rdata <= 32'h0000_0000;
			end else if (s_rready)
				s_rvalid <= 1'b0;
		end
	end
	// ----------------------------------------
	// channel engine and registers
	// ----------------------------------------
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < 4; i = i + 1) begin
				src[i] <= 32'h0000_0000;
				dst[i] <= 32'h0000_0000;
				cnt[i] <= 24'h00_0000;
				ctrl[i] <= `DCL_CTRL_RESET;
			end
			done <= 4'h0;
			cerr <= 4'h0;
			link_req <= 4'h0;
			state <= ST_IDLE;
			cur <= 2'h0;
			data <= 32'h0000_0000;
			mem_addr <= 32'h0000_0000;
			mem_size <= 2'h0;
			mem_read <= 1'b0;
			mem_write <= 1'b0;
			mem_wdata <= 32'h0000_0000;
			irq_event <= 4'h0;
		end else begin
			irq_event <= 4'h0;
			if (wr_go && wr_hit) begin
				case (wreg)
					`DCL_OFF_SRC: src[wch] <= merge(src[wch], w_data, bmask);
					`DCL_OFF_DST: dst[wch] <= merge(dst[wch], w_data, bmask);
					`DCL_OFF_CNT: begin
						cnt[wch] <= cnt_merged[23:0];
						if (w_strb[3] && w_data[`DCL_STAT_DONE_BIT]) begin
							done[wch] <= 1'b0;
							cerr[wch] <= 1'b0;
						end
					end
					`DCL_OFF_CTRL: ctrl[wch] <= merge(ctrl[wch], w_data,
						bmask & `DCL_CTRL_WMASK);
					default: ;
				endcase
			end
			case (state)
				ST_IDLE: begin
					if (arb_any) begin
						cur <= arb_pick;
						// (R11) start clears on activation
						ctrl[arb_pick][`DCL_CTRL_START_BIT] <= 1'b0;
						// (R6) (R21) link request consumed on activation
						link_req[arb_pick] <= 1'b0;
						state <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					// (R22) (R13) errors stop before any access
					if (link_bad || size_bad) begin
						cerr[cur] <= 1'b1;
						done[cur] <= 1'b1;
						irq_event[cur] <= cc[`DCL_CTRL_IRQ_EN_BIT];
						state <= ST_IDLE;
					end else if (cb == 24'h00_0000) begin
						done[cur] <= 1'b1;
						state <= ST_IDLE;
					end else begin
						mem_addr <= cs;
						mem_size <= xsz;
						mem_read <= 1'b1;
						state <= ST_READ;
					end
				end
				ST_READ: begin
					if (mem_ack) begin
						mem_read <= 1'b0;
						data <= mem_rdata;
						mem_wdata <= mem_rdata;
						mem_addr <= cd;
						mem_write <= 1'b1;
						state <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					if (mem_ack) begin
						mem_write <= 1'b0;
						// (R16) increment after success
						if (cc[`DCL_CTRL_SINC_BIT] || src_aligned)
							src[cur] <= cs + {29'h0, xbytes};
						if (cc[`DCL_CTRL_DINC_BIT] || dst_aligned)
							dst[cur] <= cd + {29'h0, xbytes};
						cnt[cur] <= last ? 24'h00_0000 : cb_next;
						// (R1) (R2) (R3) (R4) (R5) link events
						case (lk)
							`DCL_LINK_STEP_LAST: begin
								if (last)
									link_req[second_link_channel] <= 1'b1;
								else if (steal)
									link_req[first_link_channel] <= 1'b1;
							end
							`DCL_LINK_STEP: begin
								if (steal)
									link_req[first_link_channel] <= 1'b1;
							end
							`DCL_LINK_LAST: begin
								if (last)
									link_req[first_link_channel] <= 1'b1;
							end
							default: ;
						endcase
						if (last) begin
							done[cur] <= 1'b1;
							irq_event[cur] <= cc[`DCL_CTRL_IRQ_EN_BIT];
							// (R19) disable request at zero
							if (cc[`DCL_CTRL_DREQ_BIT])
								ctrl[cur][`DCL_CTRL_ERQ_BIT] <= 1'b0;
						end
						// (R18) steal stops after one transfer
						state <= (last || steal) ? ST_IDLE : ST_NEXT;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // dcl_dma

/* File: verif/dcl_dma_assertions.sv */
// port checks for the dma core
`timescale 1ns/1ps
module dcl_dma_assertions (
	input wire aclk,
	input wire aresetn,
	input wire s_awready,
	input wire s_wready,
	input wire [1:0] s_bresp,
	input wire s_bvalid,
	input wire s_bready,
	input wire s_arvalid,
	input wire s_arready,
	input wire [31:0] s_rdata,
	input wire s_rvalid,
	input wire s_rready,
	input wire [31:0] mem_addr,
	input wire mem_read,
	input wire mem_write,
	input wire [31:0] mem_wdata,
	input wire mem_ack
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence rd_done;
		mem_read && mem_ack;
	endsequence
	sequence wr_go;
		mem_write && !mem_read;
	endsequence
	chk_read_then_write: assert property (rd_done |=> ##[0:4] wr_go)
		else $error("no write after source read");
	chk_read_hold: assert property (mem_read && !mem_ack |=> mem_read && $stable(mem_addr))
		else $error("read dropped before ack");
	chk_write_hold: assert property (mem_write && !mem_ack |=> wr_go and $stable(mem_wdata))
		else $error("write dropped before ack");
	chk_one_access: assert property (!(mem_read && mem_write))
		else $error("read and write together");
	chk_bresp_stand: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write response not held");
	chk_rdata_stand: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read data not held");
	chk_ar_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read answer late");
	chk_ready_pulse: assert property (s_awready || s_wready |=> !s_awready && !s_wready)
		else $error("ready longer than one cycle");
endmodule // dcl_dma_assertions
bind dcl_dma dcl_dma_assertions u_chk (.aclk, .aresetn, .s_awready, .s_wready, .s_bresp,
	.s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready,
	.mem_addr, .mem_read, .mem_write, .mem_wdata, .mem_ack);

/* File: verif/dcl_dma_tb.sv */
// testbench for the dma core
`timescale 1ns/1ps
module dcl_dma_tb;
	reg aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0;
	reg s_arvalid = 0, s_rready = 0;
	reg [7:0] s_awaddr = 0, s_araddr = 0;
	reg [31:0] s_wdata = 0;
	reg [3:0] periph_req = 0;
	reg [2:0] lat = 0;
	wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_read, mem_write, mem_ack;
	wire [1:0] s_bresp, s_rresp, mem_size;
	wire [31:0] s_rdata, mem_addr, mem_wdata, mem_rdata, wr_addr, wr_data;
	wire [3:0] irq_event;
	integer wr_cnt, err_total = 0, compares = 0, n0;
	reg [31:0] d;
	reg [1:0] r;
	reg [3:0] irq_seen = 0;
	reg [1:0] wr_size = 0;
	always #50 aclk = ~aclk;
	// sticky interrupt pulses and size of the last write
	always @(posedge aclk) begin
		irq_seen <= irq_seen | irq_event;
		if (mem_write && mem_ack)
			wr_size <= mem_size;
	end
	dcl_dma dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .periph_req,
		.mem_addr, .mem_size, .mem_read, .mem_write, .mem_wdata, .mem_rdata, .mem_ack,
		.irq_event);
	dcl_mem_model u_mem (.aclk, .mem_addr, .mem_read, .mem_write, .mem_wdata, .lat,
		.mem_rdata, .mem_ack, .wr_addr, .wr_data, .wr_cnt);
	task automatic chk(input string n, input [31:0] e, input [31:0] g);
		compares = compares + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input [7:0] a, input [31:0] v);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		r = s_bresp;
		s_bready <= 1'b1;
		@(posedge aclk);
		s_bready <= 1'b0;
	endtask
	task automatic rd(input [7:0] a, output [31:0] v, output [1:0] rr);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_arready);
		s_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_rvalid);
		s_rready <= 1'b1;
		@(posedge aclk);
		v = s_rdata;
		rr = s_rresp;
		s_rready <= 1'b0;
	endtask
	task automatic rc(input string n, input [7:0] a, input [31:0] m, input [31:0] e);
		rd(a, d, r);
		chk(n, e, d & m);
	endtask
	task automatic poll(input [7:0] a, input integer b);
		integer i;
		d = 0;
		for (i = 0; i < 60 && d[b] !== 1'b1; i = i + 1) rd(a, d, r);
		chk("poll_bit", 32'h1, {31'h0, d[b]});
	endtask
	task automatic setup(input [7:0] c, input [31:0] s, input [31:0] t, input [31:0] n,
		input [31:0] ctl);
		wr(c << 4, s);
		wr((c << 4) + 8'h4, t);
		wr((c << 4) + 8'h8, n | 32'h0100_0000);
		wr((c << 4) + 8'hC, ctl);
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge aclk);
		err_total = err_total + 1;
		stop_test;
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rc("ctrl_reset", 8'h1C, 32'hFFFF_FFFF, 32'h0);
		wr(8'h1C, 32'h0000_00FF);
		rc("ctrl_rsvd", 8'h1C, 32'hFFFF_FFFF, 32'h0000_00BF);
		rd(8'h40, d, r);
		chk("unmapped", 32'h2, {30'h0, r});
		wr(8'h40, 32'h1);
		chk("wr_unmapped", 32'h2, {30'h0, r});
		$display("test registers done");
		n0 = wr_cnt;
		lat <= 3'h2;
		setup(0, 32'h100, 32'h200, 32'h8, 32'h0049_0000);
		poll(8'h08, 24);
		chk("writes", n0 + 2, wr_cnt);
		chk("dst", 32'h0000_0204, wr_addr);
		chk("data", 32'hFEFB_0104, wr_data);
		rc("start", 8'h0C, 32'hFFFF_FFFF, 32'h0048_0000);
		$display("test continuous done");
		lat <= 3'h0;
		setup(2, 32'h300, 32'h310, 32'h1, 32'h0012_0000);
		setup(3, 32'h320, 32'h330, 32'h1, 32'h0012_0000);
		setup(1, 32'h340, 32'h350, 32'h2, 32'h2013_001B);
		poll(8'h28, 24);
		rc("ch1_count", 8'h18, 32'h01FF_FFFF, 32'h1);
		rc("ch3_idle", 8'h38, 32'h0100_0000, 32'h0);
		wr(8'h1C, 32'h2013_001B);
		poll(8'h38, 24);
		$display("test link done");
		n0 = wr_cnt;
		setup(0, 32'h400, 32'h410, 32'h4, 32'h0001_0030);
		poll(8'h08, 30);
		setup(2, 32'h500, 32'h510, 32'h4, 32'h0001_001E);
		poll(8'h28, 30);
		setup(1, 32'h401, 32'h410, 32'h4, 32'h0001_0100);
		poll(8'h18, 30);
		chk("err_writes", n0, wr_cnt);
		chk("irq", 32'h2, {28'h0, irq_seen});
		$display("test errors done");
		setup(2, 32'h5F0, 32'h5F4, 32'h4, 32'h6000_0080);
		setup(3, 32'h600, 32'h610, 32'h4, 32'h6000_0080);
		rc("ch3_wait", 8'h38, 32'h0100_0000, 32'h0);
		periph_req <= 4'hC;
		poll(8'h38, 24);
		periph_req <= 4'h0;
		chk("prio", 32'h610, wr_addr);
		rc("ch3_erq", 8'h3C, 32'hFFFF_FFFF, 32'h2000_0080);
		$display("test peripheral done");
		lat <= 3'h1;
		setup(2, 32'h700, 32'h710, 32'h1, 32'h0012_0000);
		setup(0, 32'h720, 32'h730, 32'h2, 32'h0013_0028);
		poll(8'h08, 24);
		rc("no_link", 8'h28, 32'h0100_0000, 32'h0);
		setup(0, 32'h740, 32'h750, 32'h1, 32'h2013_0028);
		poll(8'h28, 24);
		n0 = wr_cnt;
		setup(3, 32'h800, 32'h810, 32'h4, 32'h0020_0000);
		setup(1, 32'h902, 32'h910, 32'h8, 32'h0069_003C);
		poll(8'h38, 24);
		chk("link_writes", n0 + 3, wr_cnt);
		chk("size", 32'h0, {30'h0, wr_size});
		rc("src_inc", 8'h10, 32'hFFFF_FFFF, 32'h0000_090A);
		rc("src_hold", 8'h30, 32'hFFFF_FFFF, 32'h0000_0800);
		setup(1, 32'h901, 32'h920, 32'h4, 32'h1003_0000);
		poll(8'h18, 24);
		rc("aa_ok", 8'h18, 32'h4000_0000, 32'h0);
		$display("test modes done");
		stop_test;
	end
endmodule // dcl_dma_tb

/* File: verif/dcl_mem_model.sv */
// memory model answering the dma master
`timescale 1ns/1ps
module dcl_mem_model (
	input wire aclk,
	input wire [31:0] mem_addr,
	input wire mem_read,
	input wire mem_write,
	input wire [31:0] mem_wdata,
	input wire [2:0] lat,
	output reg [31:0] mem_rdata,
	output reg mem_ack,
	output reg [31:0] wr_addr,
	output reg [31:0] wr_data,
	output integer wr_cnt
);
	integer w;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		w = 0;
		wr_cnt = 0;
	end
	// read data only valid with ack, toggles otherwise
	always @(posedge aclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if ((mem_read || mem_write) && !mem_ack) begin
			if (w < lat) begin
				w <= w + 1;
			end else begin
				w <= 0;
				mem_ack <= 1'b1;
				mem_rdata <= {~mem_addr[15:0], mem_addr[15:0]};
				if (mem_write) begin
					wr_addr <= mem_addr;
					wr_data <= mem_wdata;
					wr_cnt <= wr_cnt + 1;
				end
			end
		end
	end
endmodule // dcl_mem_model
